// [radio_event_status_flags.sv]
// Notes on behaviour
// - In CRC mode, a write CRC mismatch sets the SPI CRC error flag.
// - With CRC mode off, the SPI CRC error flag always reads set.
// - Count write CRC errors only while event counting is enabled.
// - With filtering on, a valid ack-request frame sets the ack trigger flag.
// - Transmit-begins flag sets when preamble sending starts.
// - Preamble-sent flag sets when delimiter sending starts.
// - Header-sent flag sets once the PHY header is out.
// - Frame-sent flag sets at payload end, or after header for empty frames; here only tx_payload_done sets it, tx_header_done does not.
// - Writing a one to a flag bit clears that flag.
// - Preamble-detected flag sets once the preamble is confirmed.
// - Delimiter-detected flag sets when the delimiter is found.
// - Analyser-done flag sets when timestamp adjustment completes; timestamp readable.
// - Adjusted timestamp is marker time minus programmed antenna delay.
// - With late sequence processing, analyser-done waits for that processing.
// - Header-decoded flag sets when PHY header decoding finishes.
// - Uncorrectable header error sets header-error flag and aborts reception.
// - Count header errors only while event counting is enabled.
// - Frame-ready flag sets when reception completes.
// - CRC-good flag sets with frame-ready only if the CRC matches.
// - Flags latch when set; writing zero leaves them unchanged.
// - Interrupt output is high while any enabled flag is set.
//
// Design decision made here: the plain strobed port.
module radio_event_status_flags (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic        clock_enable,
  input  wire logic [7:0]  address,
  input  wire logic [47:0] write_data,
  input  wire logic        write_strobe,
  input  wire logic        read_strobe,
  output logic      [47:0] read_data,
  input  wire logic        spi_write_done,
  input  wire logic        spi_crc_mismatch,
  input  wire logic        ack_frame_received,
  input  wire logic        tx_preamble_start,
  input  wire logic        tx_delimiter_start,
  input  wire logic        tx_header_done,
  input  wire logic        tx_payload_done,
  input  wire logic        rx_preamble_confirmed,
  input  wire logic        rx_delimiter_found,
  input  wire logic        rx_header_done,
  input  wire logic        rx_header_uncorrectable,
  input  wire logic        rx_complete,
  input  wire logic        rx_crc_match,
  input  wire logic        analyser_preamble_done,
  input  wire logic        analyser_sequence_done,
  input  wire logic [39:0] ranging_marker,
  output logic             rx_abort,
  output logic             irq
);
  import event_status_pkg::*;

  logic        reset_meta;
  logic        reset_sync;
  logic [47:0] status;
  logic [47:0] next_status;
  logic [31:0] event_enable;
  logic [31:0] next_event_enable;
  logic [3:0]  control;
  logic [3:0]  next_control;
  logic [15:0] rx_antenna_delay;
  logic [15:0] next_rx_antenna_delay;
  logic [15:0] spi_crc_count;
  logic [15:0] next_spi_crc_count;
  logic [15:0] header_err_count;
  logic [15:0] next_header_err_count;
  logic [39:0] rx_timestamp;
  logic [39:0] next_rx_timestamp;
  logic [47:0] next_read_data;
  logic        next_rx_abort;
  logic        next_irq;
  logic [47:0] set_events;
  logic        spi_crc_error;
  logic        analyser_finish;

  // Reset release is synchronised; assertion stays asynchronous
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reset_meta <= 1'b0;
      reset_sync <= 1'b0;
    end else begin
      reset_meta <= 1'b1;
      reset_sync <= reset_meta;
    end
  end

  assign spi_crc_error   = control[ctl_crc_mode_bit] && spi_write_done && spi_crc_mismatch;
  // Late sequence mode ignores the earlier preamble result
  assign analyser_finish = control[ctl_late_seq_bit] ? analyser_sequence_done
                                                     : analyser_preamble_done;

  always_comb begin
    set_events                     = '0;
    set_events[spi_crc_bit]        = spi_crc_error;
    set_events[auto_ack_bit]       = control[ctl_filter_bit] && ack_frame_received;
    set_events[tx_begins_bit]      = tx_preamble_start;
    set_events[tx_preamble_bit]    = tx_delimiter_start;
    set_events[tx_header_bit]      = tx_header_done;
    set_events[tx_frame_bit]       = tx_payload_done;
    set_events[rx_preamble_bit]    = rx_preamble_confirmed;
    set_events[rx_delimiter_bit]   = rx_delimiter_found;
    set_events[analyser_done_bit]  = analyser_finish;
    set_events[rx_header_bit]      = rx_header_done;
    set_events[rx_header_err_bit]  = rx_header_uncorrectable;
    set_events[rx_frame_ready_bit] = rx_complete;
    set_events[rx_crc_good_bit]    = rx_complete && rx_crc_match;
  end

  // Status flags: clear by write-one, then merge the new events
  always_comb begin
    next_status = status;
    if (write_strobe && address == system_event_status_addr) begin
      next_status = status & ~(write_data & flag_mask);
    end
    // Set is applied after the clear so a coincident event survives
    next_status = next_status | set_events;
    // The flag means nothing without CRC mode, so it is pinned high
    if (!control[ctl_crc_mode_bit]) begin
      next_status[spi_crc_bit] = 1'b1;
    end
  end

  always_ff @(posedge clock or negedge reset_sync) begin
    if (!reset_sync) begin
      status <= status_reset;
    end else if (clock_enable) begin
      status <= next_status;
    end
  end

  // Software configuration
  always_comb begin
    next_event_enable     = event_enable;
    next_control          = control;
    next_rx_antenna_delay = rx_antenna_delay;
    if (write_strobe) begin
      unique case (address)
        event_enable_addr:  next_event_enable = write_data[31:0];
        control_addr:       next_control = write_data[3:0];
        antenna_delay_addr: next_rx_antenna_delay = write_data[15:0];
        default:            next_control = control;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_sync) begin
    if (!reset_sync) begin
      event_enable     <= enable_reset;
      control          <= control_reset;
      rx_antenna_delay <= antenna_reset;
    end else if (clock_enable) begin
      event_enable     <= next_event_enable;
      control          <= next_control;
      rx_antenna_delay <= next_rx_antenna_delay;
    end
  end

  // Error counters wrap silently; software reads the difference
  always_comb begin
    next_spi_crc_count    = spi_crc_count;
    next_header_err_count = header_err_count;
    if (control[ctl_count_en_bit] && spi_crc_error) begin
      next_spi_crc_count = spi_crc_count + 16'h0001;
    end
    if (control[ctl_count_en_bit] && rx_header_uncorrectable) begin
      next_header_err_count = header_err_count + 16'h0001;
    end
  end

  always_ff @(posedge clock or negedge reset_sync) begin
    if (!reset_sync) begin
      spi_crc_count    <= count_reset;
      header_err_count <= count_reset;
    end else if (clock_enable) begin
      spi_crc_count    <= next_spi_crc_count;
      header_err_count <= next_header_err_count;
    end
  end

  // Timestamp is latched with the done flag so both agree when read
  always_comb begin
    next_rx_timestamp = rx_timestamp;
    if (analyser_finish) begin
      next_rx_timestamp = ranging_marker - {24'h00_0000, rx_antenna_delay};
    end
  end

  always_ff @(posedge clock or negedge reset_sync) begin
    if (!reset_sync) begin
      rx_timestamp <= timestamp_reset;
    end else if (clock_enable) begin
      rx_timestamp <= next_rx_timestamp;
    end
  end

  // Read data stand one cycle only, zero otherwise
  always_comb begin
    next_read_data = '0;
    if (read_strobe) begin
      unique case (address)
        system_event_status_addr: next_read_data = status;
        event_enable_addr:        next_read_data = {16'h0000, event_enable};
        control_addr:             next_read_data = {44'h000_0000_0000, control};
        antenna_delay_addr:       next_read_data = {32'h0000_0000, rx_antenna_delay};
        spi_crc_count_addr:       next_read_data = {32'h0000_0000, spi_crc_count};
        header_err_count_addr:    next_read_data = {32'h0000_0000, header_err_count};
        timestamp_addr:           next_read_data = {8'h00, rx_timestamp};
        default:                  next_read_data = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge reset_sync) begin
    if (!reset_sync) begin
      read_data <= '0;
    end else if (clock_enable) begin
      read_data <= next_read_data;
    end
  end

  // Outputs toward the radio and the host
  always_comb begin
    next_rx_abort = rx_header_uncorrectable;
    next_irq      = |(status[31:0] & event_enable);
  end

  always_ff @(posedge clock or negedge reset_sync) begin
    if (!reset_sync) begin
      rx_abort <= 1'b0;
      irq      <= 1'b0;
    end else if (clock_enable) begin
      rx_abort <= next_rx_abort;
      irq      <= next_irq;
    end
  end

  sequence s_clear_write;
    write_strobe && address == system_event_status_addr && write_data[tx_frame_bit];
  endsequence

  sequence s_keep_write;
    write_strobe && address == system_event_status_addr && !write_data[rx_frame_ready_bit];
  endsequence

  sequence s_late_wait;
    control[ctl_late_seq_bit] && !analyser_sequence_done;
  endsequence

  sequence s_ack_clear;
    write_strobe && address == system_event_status_addr && write_data[auto_ack_bit];
  endsequence

  a_crc_error_sets: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && spi_crc_error |=> status[spi_crc_bit])
    else $error("crc error did not set flag");
  a_crc_off_set: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && !control[ctl_crc_mode_bit] |=> status[spi_crc_bit])
    else $error("crc flag low while mode off");
  a_crc_count_step: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && !control[ctl_count_en_bit] |=> $stable(spi_crc_count))
    else $error("crc counter moved while disabled");
  a_ack_filter: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && !status[auto_ack_bit] && !control[ctl_filter_bit] |=> !status[auto_ack_bit])
    else $error("ack flag set without filtering");
  a_clear_frame_sent: assert property (@(posedge clock) disable iff (!reset_sync)
    (s_clear_write and (clock_enable && !tx_payload_done)) |=> !status[tx_frame_bit])
    else $error("write one did not clear flag");
  a_event_wins: assert property (@(posedge clock) disable iff (!reset_sync)
    (s_clear_write and (clock_enable && tx_payload_done)) |=> status[tx_frame_bit])
    else $error("event lost to clear");
  a_flag_latched: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && status[rx_frame_ready_bit] && !write_strobe |=> status[rx_frame_ready_bit])
    else $error("flag dropped without clear");
  a_crc_good_pair: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && rx_complete && rx_crc_match |=> status[rx_crc_good_bit] && status[rx_frame_ready_bit])
    else $error("crc good not set with frame ready");
  a_timestamp_adjust: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && analyser_finish |=>
      rx_timestamp == $past(ranging_marker) - {24'h00_0000, $past(rx_antenna_delay)})
    else $error("timestamp not adjusted by delay");
  a_irq_follows: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && |(status[31:0] & event_enable) |=> irq)
    else $error("irq not raised");
  a_header_abort: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && rx_header_uncorrectable |=> rx_abort && status[rx_header_err_bit])
    else $error("header error not flagged");

  // Event inputs land in their flags one cycle later; ack needs filtering, CRC good needs rx_complete
  a_ack_set: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && control[ctl_filter_bit] && ack_frame_received |=> status[auto_ack_bit])
    else $error("ack flag not set");
  a_tx_begin_set: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && tx_preamble_start |=> status[tx_begins_bit])
    else $error("tx begins flag not set");
  a_tx_preamble_set: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && tx_delimiter_start |=> status[tx_preamble_bit])
    else $error("tx preamble flag not set");
  a_tx_header_set: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && tx_header_done |=> status[tx_header_bit])
    else $error("tx header flag not set");
  a_tx_frame_set: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && tx_payload_done |=> status[tx_frame_bit])
    else $error("tx frame flag not set");
  a_rx_preamble_set: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && rx_preamble_confirmed |=> status[rx_preamble_bit])
    else $error("rx preamble flag not set");
  a_rx_delimiter_set: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && rx_delimiter_found |=> status[rx_delimiter_bit])
    else $error("rx delimiter flag not set");
  a_analyser_done_set: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && analyser_finish |=> status[analyser_done_bit])
    else $error("analyser done flag not set");
  a_late_seq_hold: assert property (@(posedge clock) disable iff (!reset_sync)
    (s_late_wait and (clock_enable && !status[analyser_done_bit])) |=> !status[analyser_done_bit])
    else $error("analyser done set before sequence");
  a_rx_header_set: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && rx_header_done |=> status[rx_header_bit])
    else $error("header decoded flag not set");
  a_frame_ready_set: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && rx_complete |=> status[rx_frame_ready_bit])
    else $error("frame ready flag not set");
  a_crc_good_gate: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && !status[rx_crc_good_bit] && !(rx_complete && rx_crc_match)
      |=> !status[rx_crc_good_bit])
    else $error("crc good set without match");

  // Counters
  a_crc_count_inc: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && control[ctl_count_en_bit] && spi_crc_error
      |=> spi_crc_count == $past(spi_crc_count) + 16'h0001)
    else $error("crc counter did not step");
  a_header_count_step: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && !control[ctl_count_en_bit] |=> $stable(header_err_count))
    else $error("header counter moved while disabled");
  a_header_count_inc: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && control[ctl_count_en_bit] && rx_header_uncorrectable
      |=> header_err_count == $past(header_err_count) + 16'h0001)
    else $error("header counter did not step");

  // Clearing, keeping and reserved bits
  a_zero_write_keeps: assert property (@(posedge clock) disable iff (!reset_sync)
    (s_keep_write and (clock_enable && status[rx_frame_ready_bit])) |=> status[rx_frame_ready_bit])
    else $error("zero write cleared flag");
  a_clear_ack: assert property (@(posedge clock) disable iff (!reset_sync)
    (s_ack_clear and (clock_enable && !ack_frame_received)) |=> !status[auto_ack_bit])
    else $error("ack flag not cleared");
  a_reserved_zero: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable |=> status[47:15] == 33'h0_0000_0000 && status[1:0] == 2'h0)
    else $error("reserved status bit set");

  // Register port, outputs and clock enable
  a_enable_write: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && write_strobe && address == event_enable_addr
      |=> event_enable == $past(write_data[31:0]))
    else $error("enable mask write lost");
  a_control_write: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && write_strobe && address == control_addr |=> control == $past(write_data[3:0]))
    else $error("control write lost");
  a_delay_write: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && write_strobe && address == antenna_delay_addr
      |=> rx_antenna_delay == $past(write_data[15:0]))
    else $error("antenna delay write lost");
  a_read_status: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && read_strobe && address == system_event_status_addr
      |=> read_data == $past(status))
    else $error("status read wrong");
  a_read_idle: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && !read_strobe |=> read_data == 48'h0000_0000_0000)
    else $error("read data not cleared");
  a_irq_drops: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && !(|(status[31:0] & event_enable)) |=> !irq)
    else $error("irq high without enabled flag");
  a_abort_pulse: assert property (@(posedge clock) disable iff (!reset_sync)
    clock_enable && !rx_header_uncorrectable |=> !rx_abort)
    else $error("abort without header error");
  a_freeze_state: assert property (@(posedge clock) disable iff (!reset_sync)
    !clock_enable |=> $stable(status) && $stable(read_data) && $stable(irq))
    else $error("state moved while clock enable low");
endmodule // radio_event_status_flags

// [event_status_pkg.sv]
package event_status_pkg;
  localparam logic [7:0]  system_event_status_addr = 8'h44;
  localparam logic [7:0]  event_enable_addr        = 8'h3c;
  localparam logic [7:0]  spi_crc_count_addr       = 8'h1a;
  localparam logic [7:0]  header_err_count_addr    = 8'h04;
  localparam logic [7:0]  timestamp_addr           = 8'h64;
  localparam logic [7:0]  antenna_delay_addr       = 8'h00;
  localparam logic [7:0]  control_addr             = 8'h10;
  localparam int spi_crc_bit        = 2;
  localparam int auto_ack_bit       = 3;
  localparam int tx_begins_bit      = 4;
  localparam int tx_preamble_bit    = 5;
  localparam int tx_header_bit      = 6;
  localparam int tx_frame_bit       = 7;
  localparam int rx_preamble_bit    = 8;
  localparam int rx_delimiter_bit   = 9;
  localparam int analyser_done_bit  = 10;
  localparam int rx_header_bit      = 11;
  localparam int rx_header_err_bit  = 12;
  localparam int rx_frame_ready_bit = 13;
  localparam int rx_crc_good_bit    = 14;
  localparam int ctl_crc_mode_bit   = 0;
  localparam int ctl_count_en_bit   = 1;
  localparam int ctl_filter_bit     = 2;
  localparam int ctl_late_seq_bit   = 3;
  localparam int flag_lo            = 2;
  localparam int flag_hi            = 14;
  localparam logic [47:0] status_reset    = 48'h0000_0000_0004;
  localparam logic [47:0] flag_mask       = 48'h0000_0000_7ffc;
  localparam logic [31:0] enable_reset    = 32'h0000_0000;
  localparam logic [3:0]  control_reset   = 4'h0;
  localparam logic [15:0] antenna_reset   = 16'h0000;
  localparam logic [15:0] count_reset     = 16'h0000;
  localparam logic [39:0] timestamp_reset = 40'h00_0000_0000;
endpackage

// [host_bus_model.sv]
module host_bus_model (
  input  wire logic        clock,
  output logic      [7:0]  address,
  output logic      [47:0] write_data,
  output logic             write_strobe,
  output logic             read_strobe
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    address      = 8'hff;
    write_data   = '0;
    write_strobe = 1'b0;
    read_strobe  = 1'b0;
  end
  // Lines flip on release so a stale address or data word never looks live
  task automatic access(input logic wr, input logic [7:0] a, input logic [47:0] d);
    @(posedge clock);
    address      <= a;
    write_data   <= d;
    write_strobe <= wr;
    read_strobe  <= !wr;
    @(posedge clock);
    write_strobe <= 1'b0;
    read_strobe  <= 1'b0;
    address      <= ~a;
    write_data   <= ~d;
  endtask
endmodule // host_bus_model

// [tb.sv]
module tb;
  import event_status_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  address;
  logic [47:0] write_data;
  logic        write_strobe;
  logic        read_strobe;
  logic [47:0] read_data;
  logic        rx_abort;
  logic        irq;
  logic [14:0] ev = '0;
  logic        seq_done = 1'b0;
  logic [39:0] marker = '0;
  logic [15:0] lfsr = 16'hd7c5;
  logic [15:0] dly;
  logic [47:0] exp_v;
  logic [47:0] exp_q[$];
  logic        pend = 1'b0;
  logic        ce = 1'b1;
  int          err_total = 0;
  int          compares = 0;
  int          cycles = 0;
  always #4 clock = ~clock;
  host_bus_model host_bus_model_inst (.clock(clock), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe));
  radio_event_status_flags radio_event_status_flags_inst (.clock(clock), .resetn(resetn),
    .clock_enable(ce), .address(address), .write_data(write_data),
    .write_strobe(write_strobe), .read_strobe(read_strobe), .read_data(read_data),
    .spi_write_done(ev[2]), .spi_crc_mismatch(ev[2]), .ack_frame_received(ev[3]),
    .tx_preamble_start(ev[4]), .tx_delimiter_start(ev[5]), .tx_header_done(ev[6]),
    .tx_payload_done(ev[7]), .rx_preamble_confirmed(ev[8]), .rx_delimiter_found(ev[9]),
    .analyser_preamble_done(ev[10]), .rx_header_done(ev[11]),
    .rx_header_uncorrectable(ev[12]), .rx_complete(ev[13] | ev[14]), .rx_crc_match(ev[14]),
    .analyser_sequence_done(seq_done), .ranging_marker(marker), .rx_abort(rx_abort),
    .irq(irq));
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input logic [47:0] seen, input logic [47:0] expd);
    compares++;
    if (seen !== expd) begin
      err_total++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, expd);
    end
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [47:0] d);
    host_bus_model_inst.access(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [47:0] e);
    exp_q.push_back(e);
    host_bus_model_inst.access(1'b0, a, 48'h0);
  endtask
  task automatic pulse(input logic [14:0] v, input logic s);
    @(posedge clock);
    ev       <= v;
    seq_done <= s;
    @(posedge clock);
    ev       <= '0;
    seq_done <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe, so sample mid-cycle
  always @(posedge clock) pend <= read_strobe;
  always @(negedge clock) if (pend === 1'b1) check(read_data, exp_q.pop_front());
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      err_total++;
      tally_and_finish();
    end
  end
  initial begin
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    rd(system_event_status_addr, status_reset);
    wr(control_addr, 48'h7);
    wr(system_event_status_addr, 48'h4);
    rd(system_event_status_addr, 48'h0);
    for (int b = flag_lo; b <= flag_hi; b++) begin
      exp_v = (b == rx_crc_good_bit) ? 48'h6000 : (48'h1 << b);
      pulse(15'h1 << b, 1'b0);
      wr(system_event_status_addr, 48'h0);
      rd(system_event_status_addr, exp_v);
      wr(system_event_status_addr, exp_v);
      rd(system_event_status_addr, 48'h0);
    end
    rd(spi_crc_count_addr, 48'h1);
    rd(header_err_count_addr, 48'h1);
    wr(control_addr, 48'h5);
    pulse(15'h4, 1'b0);
    wr(system_event_status_addr, 48'h4);
    rd(spi_crc_count_addr, 48'h1);
    lfsr = lfsr_next(lfsr);
    dly = lfsr;
    lfsr = lfsr_next(lfsr);
    @(posedge clock);
    marker <= {lfsr, dly, lfsr[7:0]};
    wr(control_addr, 48'hd);
    wr(antenna_delay_addr, {32'h0, dly});
    pulse(15'h400, 1'b0);
    rd(system_event_status_addr, 48'h0);
    pulse(15'h0, 1'b1);
    rd(system_event_status_addr, 48'h400);
    rd(timestamp_addr, {8'h0, marker - {24'h0, dly}});
    wr(system_event_status_addr, 48'h400);
    fork
      wr(system_event_status_addr, 48'h10);
      pulse(15'h10, 1'b0);
    join
    rd(system_event_status_addr, 48'h10);
    wr(system_event_status_addr, 48'h10);
    wr(event_enable_addr, 48'h80);
    pulse(15'h80, 1'b0);
    @(posedge clock);
    #1 check(irq, 48'h1);
    wr(system_event_status_addr, 48'h80);
    repeat (2) @(posedge clock);
    #1 check(irq, 48'h0);
    @(posedge clock);
    ce <= 1'b0;
    pulse(15'h100, 1'b0);
    ce <= 1'b1;
    rd(system_event_status_addr, 48'h0);
    pulse(15'h1000, 1'b0);
    #1 check(rx_abort, 48'h1);
    wr(system_event_status_addr, 48'h1000);
    rd(system_event_status_addr, 48'h0);
    for (int i = 0; i < 4; i++) begin
      lfsr = lfsr_next(lfsr);
      rd({1'b1, lfsr[6:0]}, 48'h0);
    end
    wr(control_addr, 48'h0);
    wr(system_event_status_addr, 48'h4);
    rd(system_event_status_addr, 48'h4);
    repeat (3) @(posedge clock);
    tally_and_finish();
  end
endmodule // tb
